// ### verilog/asc_channel.sv
// Async serial channel: registers, baud generator, transmitter, receiver
//
// Overview of operation
// - Mode select bit 0 means async framing
// - Length bit 0 gives eight data bits
// - Parity bit 0: no parity added or checked
// - Stop-length bit 0 gives one stop bit
// - Divisor 64 at 40 MHz gives 19200
// - Transmit-empty enable gates transmit-empty request
// - Receive-interrupt enable gates full and error requests
// - Transmit enable bit runs the transmitter
// - Receive enable bit runs the receiver
// - Clock field 00 uses internal baud generator
// - Status register resets to 0x84
// - Transmit-end flag resets to one
// - Halt bit one holds channel stopped
// - Four-bit field sets the interrupt level
// - Shared-level requests ranked by vector order
// - Pin mode 001 routes serial pins
// - Frame: start, data LSB first, parity, stop
// - Idle high; low level in idle starts reception
// - Sample tick at sixteen times bit rate
// - Framing, parity, overrun, break raise error request
`timescale 1ns/1ps
`default_nettype none

module asc_channel (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire asc_pkg::asc_bus_s bus,
  output logic [7:0] rd_data,
  // Serial pins
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  // Interrupt requests
  output asc_pkg::asc_irq_s irq
);

  asc_pkg::asc_state_s s;
  asc_pkg::asc_state_s next_s;

  logic run;
  logic rx_line;
  logic [15:0] baud_limit;
  logic [3:0] nbits;
  logic [7:0] rx_word;
  logic [7:0] stat_view;
  logic [7:0] rd_val;

  always_comb begin
    next_s = s;
    stat_view = {s.tx_buf_empty_flag, s.rdrf, s.orer, s.fer, s.per, s.tx_done_flag, 2'b00};
    // Channel runs only out of halt, in async mode, with internal clock
    run = !s.halt && !s.mode[asc_pkg::MODE_SYNC]
          && (s.ctrl[asc_pkg::CTRL_CKE_LO +: 2] == 2'b00);
    rx_line = (s.pin_in == asc_pkg::PIN_SEL_SERIAL) ? s.rx_s2 : 1'b1;
    nbits = s.mode[asc_pkg::MODE_CHR] ? asc_pkg::BITS_SHORT : asc_pkg::BITS_LONG;
    // Tick period is 2*(N+1)*4^cks, so a bit lasts 32*(N+1)*4^cks clocks
    baud_limit = 16'(((17'(s.brr) + 17'd1)
                 << (5'd1 + {2'b00, s.mode[asc_pkg::MODE_CKS_LO +: 2], 1'b0})) - 17'd1);
    rx_word = s.mode[asc_pkg::MODE_CHR] ? {1'b0, s.rx_sh[7:1]} : s.rx_sh;

    // Pin synchroniser
    next_s.rx_s1 = serial_in_pin;
    next_s.rx_s2 = s.rx_s1;

    // Baud generator
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.baud_cnt = 16'h0000;
    end else if (s.baud_cnt >= baud_limit) begin
      next_s.baud_cnt = 16'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.baud_cnt = s.baud_cnt + 16'h0001;
    end

    // Register read
    rd_val = 8'h00;
    case (bus.addr)
      asc_pkg::ADDR_MODE: rd_val = s.mode;
      asc_pkg::ADDR_BRR: rd_val = s.brr;
      asc_pkg::ADDR_TDATA: rd_val = s.tdata;
      asc_pkg::ADDR_CTRL: rd_val = s.ctrl;
      asc_pkg::ADDR_RDATA: rd_val = s.rdata_reg;
      asc_pkg::ADDR_STAT: rd_val = stat_view;
      asc_pkg::ADDR_AUX: rd_val = {6'h00, s.brk, s.halt};
      asc_pkg::ADDR_LEVEL: rd_val = {4'h0, s.level};
      asc_pkg::ADDR_PINMUX: rd_val = {1'b0, s.pin_in, 1'b0, s.pin_out};
      default: rd_val = 8'h00;
    endcase
    next_s.rdata = bus.rd ? rd_val : 8'h00;

    // Register write; hardware sets below win over these clears
    if (bus.wr) begin
      case (bus.addr)
        asc_pkg::ADDR_MODE: next_s.mode = bus.wdata;
        asc_pkg::ADDR_BRR: next_s.brr = bus.wdata;
        asc_pkg::ADDR_TDATA: begin
          next_s.tdata = bus.wdata;
          next_s.tx_buf_empty_flag = 1'b0;
        end
        asc_pkg::ADDR_CTRL: next_s.ctrl = bus.wdata;
        asc_pkg::ADDR_STAT: begin
          next_s.tx_buf_empty_flag = s.tx_buf_empty_flag & bus.wdata[asc_pkg::STAT_TX_BUF_EMPTY_FLAG];
          next_s.rdrf = s.rdrf & bus.wdata[asc_pkg::STAT_RDRF];
          next_s.orer = s.orer & bus.wdata[asc_pkg::STAT_ORER];
          next_s.fer = s.fer & bus.wdata[asc_pkg::STAT_FER];
          next_s.per = s.per & bus.wdata[asc_pkg::STAT_PER];
          next_s.tx_done_flag = s.tx_done_flag & bus.wdata[asc_pkg::STAT_TX_DONE_FLAG];
        end
        asc_pkg::ADDR_AUX: begin
          next_s.halt = bus.wdata[asc_pkg::AUX_HALT];
          next_s.brk = s.brk & bus.wdata[asc_pkg::AUX_BREAK];
        end
        asc_pkg::ADDR_LEVEL: next_s.level = bus.wdata[3:0];
        asc_pkg::ADDR_PINMUX: begin
          next_s.pin_out = bus.wdata[asc_pkg::PIN_OUT_LO +: 3];
          next_s.pin_in = bus.wdata[asc_pkg::PIN_IN_LO +: 3];
        end
        default: ;
      endcase
    end

    // Transmitter
    if (!run || !s.ctrl[asc_pkg::CTRL_TE]) begin
      next_s.tx_st = asc_pkg::TX_IDLE;
      next_s.txd = 1'b1;
    end else begin
      case (s.tx_st)
        asc_pkg::TX_IDLE: begin
          next_s.txd = 1'b1;
          if (!s.tx_buf_empty_flag) begin
            next_s.tx_sh = s.tdata;
            next_s.tx_buf_empty_flag = 1'b1;
            next_s.tx_done_flag = 1'b0;
            next_s.tx_par = s.mode[asc_pkg::MODE_ODD];
            next_s.tx_ph = 4'h0;
            next_s.tx_st = asc_pkg::TX_START;
          end
        end
        asc_pkg::TX_START: begin
          next_s.txd = 1'b0;
          if (s.tick) begin
            next_s.tx_ph = s.tx_ph + 4'h1;
            if (s.tx_ph == asc_pkg::TICK_LAST) begin
              next_s.tx_bit = 4'h0;
              next_s.tx_st = asc_pkg::TX_DATA;
            end
          end
        end
        asc_pkg::TX_DATA: begin
          next_s.txd = s.tx_sh[0];
          if (s.tick) begin
            next_s.tx_ph = s.tx_ph + 4'h1;
            if (s.tx_ph == asc_pkg::TICK_LAST) begin
              next_s.tx_par = s.tx_par ^ s.tx_sh[0];
              next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
              next_s.tx_bit = s.tx_bit + 4'h1;
              if (s.tx_bit + 4'h1 == nbits) begin
                next_s.tx_bit = 4'h0;
                next_s.tx_st = s.mode[asc_pkg::MODE_PE] ? asc_pkg::TX_PARITY
                                                         : asc_pkg::TX_STOP;
              end
            end
          end
        end
        asc_pkg::TX_PARITY: begin
          next_s.txd = s.tx_par;
          if (s.tick) begin
            next_s.tx_ph = s.tx_ph + 4'h1;
            if (s.tx_ph == asc_pkg::TICK_LAST) begin
              next_s.tx_st = asc_pkg::TX_STOP;
            end
          end
        end
        asc_pkg::TX_STOP: begin
          next_s.txd = 1'b1;
          if (s.tick) begin
            next_s.tx_ph = s.tx_ph + 4'h1;
            if (s.tx_ph == asc_pkg::TICK_LAST) begin
              next_s.tx_bit = s.tx_bit + 4'h1;
              if (s.mode[asc_pkg::MODE_STOP] && s.tx_bit == 4'h0) begin
                next_s.tx_st = asc_pkg::TX_STOP;
              end else if (!s.tx_buf_empty_flag) begin
                next_s.tx_sh = s.tdata;
                next_s.tx_buf_empty_flag = 1'b1;
                next_s.tx_par = s.mode[asc_pkg::MODE_ODD];
                next_s.tx_st = asc_pkg::TX_START;
              end else begin
                next_s.tx_done_flag = 1'b1;
                next_s.tx_st = asc_pkg::TX_IDLE;
              end
            end
          end
        end
        default: next_s.tx_st = asc_pkg::TX_IDLE;
      endcase
    end

    // Receiver
    if (!run || !s.ctrl[asc_pkg::CTRL_RE]) begin
      next_s.rx_st = asc_pkg::RX_IDLE;
    end else begin
      case (s.rx_st)
        asc_pkg::RX_IDLE: begin
          if (!rx_line) begin
            next_s.rx_ph = 4'h0;
            next_s.rx_st = asc_pkg::RX_START;
          end
        end
        asc_pkg::RX_START: begin
          if (s.tick) begin
            next_s.rx_ph = s.rx_ph + 4'h1;
            if (s.rx_ph == asc_pkg::TICK_MID) begin
              next_s.rx_ph = 4'h0;
              next_s.rx_bit = 4'h0;
              next_s.rx_par = s.mode[asc_pkg::MODE_ODD];
              next_s.rx_st = rx_line ? asc_pkg::RX_IDLE : asc_pkg::RX_DATA;
            end
          end
        end
        asc_pkg::RX_DATA: begin
          if (s.tick) begin
            next_s.rx_ph = s.rx_ph + 4'h1;
            if (s.rx_ph == asc_pkg::TICK_LAST) begin
              next_s.rx_sh = {rx_line, s.rx_sh[7:1]};
              next_s.rx_par = s.rx_par ^ rx_line;
              next_s.rx_bit = s.rx_bit + 4'h1;
              if (s.rx_bit + 4'h1 == nbits) begin
                next_s.rx_st = s.mode[asc_pkg::MODE_PE] ? asc_pkg::RX_PARITY
                                                         : asc_pkg::RX_STOP;
              end
            end
          end
        end
        asc_pkg::RX_PARITY: begin
          if (s.tick) begin
            next_s.rx_ph = s.rx_ph + 4'h1;
            if (s.rx_ph == asc_pkg::TICK_LAST) begin
              next_s.rx_par = s.rx_par ^ rx_line;
              next_s.rx_st = asc_pkg::RX_STOP;
            end
          end
        end
        asc_pkg::RX_STOP: begin
          if (s.tick) begin
            next_s.rx_ph = s.rx_ph + 4'h1;
            if (s.rx_ph == asc_pkg::TICK_LAST) begin
              next_s.rx_st = asc_pkg::RX_IDLE;
              if (!rx_line) begin
                next_s.fer = 1'b1;
                if (rx_word == 8'h00) begin
                  next_s.brk = 1'b1;
                end
              end
              if (s.mode[asc_pkg::MODE_PE] && s.rx_par) begin
                next_s.per = 1'b1;
              end
              if (s.rdrf) begin
                next_s.orer = 1'b1;
              end else begin
                next_s.rdata_reg = rx_word;
                next_s.rdrf = 1'b1;
              end
            end
          end
        end
        default: next_s.rx_st = asc_pkg::RX_IDLE;
      endcase
    end

    // Output pin routing
    next_s.out_oe = (s.pin_out == asc_pkg::PIN_SEL_SERIAL);
    next_s.out_pin = next_s.out_oe ? next_s.txd : 1'b1;

    // Interrupt requests
    next_s.irq.tx_empty = !s.halt && s.ctrl[asc_pkg::CTRL_TIE] && s.tx_buf_empty_flag;
    next_s.irq.rx_full = !s.halt && s.ctrl[asc_pkg::CTRL_RIE] && s.rdrf;
    next_s.irq.rx_fault = !s.halt && s.ctrl[asc_pkg::CTRL_RIE]
                          && (s.orer || s.fer || s.per);
    next_s.irq.shift_done = !s.halt && s.ctrl[asc_pkg::CTRL_TEIE] && s.tx_done_flag;
    next_s.irq.level = s.level;
    if (next_s.irq.rx_fault) begin
      next_s.irq.code = asc_pkg::IRQ_FAULT;
    end else if (next_s.irq.rx_full) begin
      next_s.irq.code = asc_pkg::IRQ_RXFULL;
    end else if (next_s.irq.tx_empty) begin
      next_s.irq.code = asc_pkg::IRQ_TXEMPTY;
    end else if (next_s.irq.shift_done) begin
      next_s.irq.code = asc_pkg::IRQ_TXDONE;
    end else begin
      next_s.irq.code = asc_pkg::IRQ_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.mode <= asc_pkg::RST_MODE;
      s.brr <= asc_pkg::RST_BRR;
      s.ctrl <= asc_pkg::RST_CTRL;
      s.tdata <= asc_pkg::RST_TDATA;
      s.tx_buf_empty_flag <= asc_pkg::RST_STAT[asc_pkg::STAT_TX_BUF_EMPTY_FLAG];
      s.tx_done_flag <= asc_pkg::RST_STAT[asc_pkg::STAT_TX_DONE_FLAG];
      s.halt <= asc_pkg::RST_AUX[asc_pkg::AUX_HALT];
      s.level <= asc_pkg::RST_LEVEL;
      s.pin_out <= asc_pkg::RST_PIN;
      s.pin_in <= asc_pkg::RST_PIN;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
      s.txd <= 1'b1;
      s.out_pin <= 1'b1;
      s.tx_st <= asc_pkg::TX_IDLE;
      s.rx_st <= asc_pkg::RX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.rdata;
  assign serial_out_pin = s.out_pin;
  assign serial_out_oe = s.out_oe;
  assign irq = s.irq;

endmodule

`default_nettype wire

// ### verilog/asc_pkg.sv
// Constants, carriers and state types of the async serial channel
package asc_pkg;
  // Register addresses
  localparam logic [31:0] ADDR_MODE = 32'hffff_c080;
  localparam logic [31:0] ADDR_BRR = 32'hffff_c082;
  localparam logic [31:0] ADDR_TDATA = 32'hffff_c083;
  localparam logic [31:0] ADDR_CTRL = 32'hffff_c084;
  localparam logic [31:0] ADDR_RDATA = 32'hffff_c085;
  localparam logic [31:0] ADDR_STAT = 32'hffff_c088;
  localparam logic [31:0] ADDR_AUX = 32'hffff_c090;
  localparam logic [31:0] ADDR_LEVEL = 32'hffff_c091;
  localparam logic [31:0] ADDR_PINMUX = 32'hffff_c092;
  // Mode register fields
  localparam int MODE_SYNC = 7;
  localparam int MODE_CHR = 6;
  localparam int MODE_PE = 5;
  localparam int MODE_ODD = 4;
  localparam int MODE_STOP = 3;
  localparam int MODE_CKS_LO = 0;
  // Control register fields
  localparam int CTRL_TIE = 7;
  localparam int CTRL_RIE = 6;
  localparam int CTRL_TE = 5;
  localparam int CTRL_RE = 4;
  localparam int CTRL_TEIE = 2;
  localparam int CTRL_CKE_LO = 0;
  // Status register fields
  localparam int STAT_TX_BUF_EMPTY_FLAG = 7;
  localparam int STAT_RDRF = 6;
  localparam int STAT_ORER = 5;
  localparam int STAT_FER = 4;
  localparam int STAT_PER = 3;
  localparam int STAT_TX_DONE_FLAG = 2;
  // Aux register fields, pin mux fields
  localparam int AUX_HALT = 0;
  localparam int AUX_BREAK = 1;
  localparam int PIN_OUT_LO = 0;
  localparam int PIN_IN_LO = 4;
  localparam logic [2:0] PIN_SEL_SERIAL = 3'h1;
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_BRR = 8'hff;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h84;
  localparam logic [7:0] RST_TDATA = 8'hff;
  localparam logic [7:0] RST_AUX = 8'h01;
  localparam logic [3:0] RST_LEVEL = 4'h0;
  localparam logic [2:0] RST_PIN = 3'h0;
  // Timing: sixteen sample ticks per bit, start checked mid-bit
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] BITS_LONG = 4'h8;
  localparam logic [3:0] BITS_SHORT = 4'h7;
  // Interrupt source codes in vector-table order
  localparam logic [2:0] IRQ_NONE = 3'h0;
  localparam logic [2:0] IRQ_FAULT = 3'h1;
  localparam logic [2:0] IRQ_RXFULL = 3'h2;
  localparam logic [2:0] IRQ_TXEMPTY = 3'h3;
  localparam logic [2:0] IRQ_TXDONE = 3'h4;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
  } asc_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
  } asc_rx_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } asc_bus_s;

  typedef struct packed {
    logic tx_empty;
    logic rx_full;
    logic rx_fault;
    logic shift_done;
    logic [3:0] level;
    logic [2:0] code;
  } asc_irq_s;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] brr;
    logic [7:0] ctrl;
    logic [7:0] tdata;
    logic [7:0] rdata_reg;
    logic tx_buf_empty_flag;
    logic rdrf;
    logic orer;
    logic fer;
    logic per;
    logic tx_done_flag;
    logic halt;
    logic brk;
    logic [3:0] level;
    logic [2:0] pin_out;
    logic [2:0] pin_in;
    logic [7:0] rdata;
    logic [15:0] baud_cnt;
    logic tick;
    logic rx_s1;
    logic rx_s2;
    asc_tx_e tx_st;
    logic [7:0] tx_sh;
    logic [3:0] tx_bit;
    logic [3:0] tx_ph;
    logic tx_par;
    logic txd;
    asc_rx_e rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_bit;
    logic [3:0] rx_ph;
    logic rx_par;
    logic out_pin;
    logic out_oe;
    asc_irq_s irq;
  } asc_state_s;
endpackage

// ### test/asc_channel_sva.sv
// Checker for the async serial channel ports
`timescale 1ns/1ps
`default_nettype none

module asc_channel_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire asc_pkg::asc_bus_s bus,
  input wire logic [7:0] rd_data,
  // Serial pins
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  // Interrupt requests
  input wire asc_pkg::asc_irq_s irq
);
  logic last_pin;
  logic [15:0] run_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Cycles the line has held its level
  always_ff @(posedge sys_clk) begin
    last_pin <= serial_out_pin;
    if (!rst_n || serial_out_pin != last_pin) begin
      run_cnt <= 16'h0000;
    end else if (run_cnt != 16'hffff) begin
      run_cnt <= run_cnt + 16'h0001;
    end
  end
  property p_reset_idle;
    $rose(rst_n) |-> serial_out_pin && !serial_out_oe && irq == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle");
  property p_stat_reset;
    $rose(rst_n) && bus.rd && bus.addr == asc_pkg::ADDR_STAT |=> rd_data == 8'h84;
  endproperty
  a_stat_reset: assert property (p_stat_reset) else $error("bad status reset");
  property p_mode_back;
    bus.wr && bus.addr == asc_pkg::ADDR_MODE ##1 bus.rd && bus.addr == asc_pkg::ADDR_MODE
      |=> rd_data == $past(bus.wdata, 2);
  endproperty
  a_mode_back: assert property (p_mode_back) else $error("mode readback wrong");
  property p_level;
    bus.wr && bus.addr == asc_pkg::ADDR_LEVEL |-> ##2 irq.level == $past(bus.wdata[3:0], 2);
  endproperty
  a_level: assert property (p_level) else $error("level not applied");
  property p_bit_len;
    $changed(serial_out_pin) |-> run_cnt >= 16'h001d;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("line bit too short");
  property p_rank;
    irq.rx_full && irq.tx_empty && !irq.rx_fault |-> irq.code == asc_pkg::IRQ_RXFULL;
  endproperty
  a_rank: assert property (p_rank) else $error("wrong source ranking");
  property p_tie_off;
    bus.wr && bus.addr == asc_pkg::ADDR_CTRL && !bus.wdata[7] |-> ##2 !irq.tx_empty;
  endproperty
  a_tie_off: assert property (p_tie_off) else $error("empty request not gated");
  property p_pin_route;
    bus.wr && bus.addr == asc_pkg::ADDR_PINMUX
      |-> ##2 serial_out_oe == ($past(bus.wdata[2:0], 2) == 3'h1);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin routing wrong");
  property p_load_clr;
    bus.wr && bus.addr == asc_pkg::ADDR_TDATA && irq.tx_empty |-> ##2 !irq.tx_empty;
  endproperty
  a_load_clr: assert property (p_load_clr) else $error("empty flag kept on write");
endmodule

bind asc_channel asc_channel_sva u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .irq(irq)
);
`default_nettype wire

// ### test/asc_remote_peer.sv
// Remote serial transceiver model
`timescale 1ns/1ps
`default_nettype none

module asc_remote_peer (
  // Clock
  input wire logic sys_clk,
  // Line from and to the channel
  input wire logic line_in,
  output logic line_out
);
  int bit_cyc = 32;
  logic [8:0] rx_q[$];
  logic [8:0] fr;
  initial line_out = 1'b1;
  // Start, data LSB first, stop
  task automatic send_char(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (bit_cyc) @(posedge sys_clk);
    end
    line_out <= 1'b1;
    @(posedge sys_clk);
  endtask
  // Falling line starts a frame, sampled mid-bit
  always begin
    @(negedge line_in);
    repeat (bit_cyc / 2) @(posedge sys_clk);
    if (line_in === 1'b0) begin
      for (int i = 0; i < 9; i++) begin
        repeat (bit_cyc) @(posedge sys_clk);
        fr[i] = line_in;
      end
      rx_q.push_back(fr);
    end
  end
endmodule
`default_nettype wire

// ### test/asc_channel_tb_top.sv
// Self-checking bench for the async serial channel
`timescale 1ns/1ps
`default_nettype none

module asc_channel_tb_top;
  typedef struct {logic [31:0] a; logic [7:0] rv; logic [7:0] wd; logic [7:0] rb;} asc_row_s;
  logic sys_clk;
  logic rst_n = 1'b0;
  asc_pkg::asc_bus_s bus = '0;
  logic [7:0] rd_data;
  logic serial_in_pin;
  logic serial_out_pin;
  logic serial_out_oe;
  asc_pkg::asc_irq_s irq;
  wire logic tx_line = serial_out_oe ? serial_out_pin : 1'b1;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] v;
  asc_row_s rows[8] = '{
    '{asc_pkg::ADDR_STAT, 8'h84, 8'hff, 8'h84},
    '{asc_pkg::ADDR_MODE, 8'h00, 8'h00, 8'h00},
    '{asc_pkg::ADDR_BRR, 8'hff, 8'h00, 8'h00},
    '{asc_pkg::ADDR_CTRL, 8'h00, 8'hf4, 8'hf4},
    '{asc_pkg::ADDR_LEVEL, 8'h00, 8'h0f, 8'h0f},
    '{asc_pkg::ADDR_PINMUX, 8'h00, 8'h11, 8'h11},
    '{32'hffff_c081, 8'h00, 8'h55, 8'h00},
    '{asc_pkg::ADDR_AUX, 8'h01, 8'h00, 8'h00}};

  asc_channel u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .irq(irq));
  asc_remote_peer u_peer (.sys_clk(sys_clk), .line_in(tx_line), .line_out(serial_in_pin));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic reg_wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask
  task automatic reg_rd(input logic [31:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 d = rd_data;
  endtask
  task automatic idle;
    @(posedge sys_clk);
    bus <= '0;
  endtask
  task automatic wait_for(input int kind, input int n);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < 30000 && !hit; i++) begin
      @(posedge sys_clk);
      #1;
      hit = (kind == 0 && u_peer.rx_q.size() >= n) || (kind == 1 && irq.rx_full === 1'b1)
            || (kind == 2 && irq.rx_fault === 1'b1);
    end
    if (!hit) begin
      bad_count++;
      $display("CHECK FAILED wait kind %0d expected 1 seen 0", kind);
    end
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus <= '{addr: asc_pkg::ADDR_STAT, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 chk("status at reset", 8'h84, rd_data);
    chk("line idle at reset", 8'h01, {7'h0, serial_out_pin});
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      reg_rd(rows[i].a, v);
      chk("reset value", rows[i].rv, v);
      reg_wr(rows[i].a, rows[i].wd);
      reg_rd(rows[i].a, v);
      chk("readback", rows[i].rb, v);
    end
    chk("irq level", 8'h0f, {4'h0, irq.level});
    chk("empty request", 8'h01, {7'h0, irq.tx_empty});
    $display("test registers done");
    reg_wr(asc_pkg::ADDR_TDATA, 8'ha5);
    reg_rd(asc_pkg::ADDR_STAT, v);
    reg_rd(asc_pkg::ADDR_STAT, v);
    chk("status while sending", 8'h80, v);
    reg_wr(asc_pkg::ADDR_TDATA, 8'h3c);
    idle();
    wait_for(0, 2);
    chk("first char", 8'ha5, u_peer.rx_q[0][7:0]);
    chk("second char", 8'h3c, u_peer.rx_q[1][7:0]);
    chk("stop bit", 8'h01, {7'h0, u_peer.rx_q[1][8]});
    // Peer samples mid stop bit; let the stop bit finish
    repeat (40) @(posedge sys_clk);
    reg_rd(asc_pkg::ADDR_STAT, v);
    chk("status after send", 8'h84, v);
    chk("shift done request", 8'h01, {7'h0, irq.shift_done});
    $display("test transmit done");
    u_peer.send_char(8'h5a, 1'b1);
    wait_for(1, 0);
    chk("rx full code", {5'h0, asc_pkg::IRQ_RXFULL}, {5'h0, irq.code});
    reg_rd(asc_pkg::ADDR_RDATA, v);
    chk("rx char", 8'h5a, v);
    reg_wr(asc_pkg::ADDR_STAT, 8'hbf);
    reg_rd(asc_pkg::ADDR_STAT, v);
    chk("status after clear", 8'h84, v);
    u_peer.send_char(8'h00, 1'b0);
    wait_for(2, 0);
    chk("fault code", {5'h0, asc_pkg::IRQ_FAULT}, {5'h0, irq.code});
    reg_rd(asc_pkg::ADDR_STAT, v);
    chk("framing flag", 8'h01, {7'h0, v[4]});
    reg_rd(asc_pkg::ADDR_AUX, v);
    chk("break flag", 8'h01, {7'h0, v[1]});
    reg_wr(asc_pkg::ADDR_STAT, 8'h84);
    reg_wr(asc_pkg::ADDR_AUX, 8'h00);
    reg_wr(asc_pkg::ADDR_CTRL, 8'h30);
    reg_rd(asc_pkg::ADDR_STAT, v);
    chk("errors cleared", 8'h84, v);
    chk("gated request", 8'h00, {7'h0, irq.tx_empty});
    chk("gated fault", 8'h00, {7'h0, irq.rx_fault});
    $display("test receive done");
    reg_wr(asc_pkg::ADDR_AUX, 8'h01);
    reg_wr(asc_pkg::ADDR_TDATA, 8'h55);
    idle();
    repeat (400) @(posedge sys_clk);
    chk("halted line", 8'h02, 8'(u_peer.rx_q.size()));
    reg_wr(asc_pkg::ADDR_AUX, 8'h00);
    idle();
    wait_for(0, 3);
    chk("released char", 8'h55, u_peer.rx_q[2][7:0]);
    $display("test halt done");
    reg_wr(asc_pkg::ADDR_MODE, 8'h80);
    reg_wr(asc_pkg::ADDR_TDATA, 8'h99);
    idle();
    repeat (400) @(posedge sys_clk);
    chk("sync mode line", 8'h03, 8'(u_peer.rx_q.size()));
    reg_wr(asc_pkg::ADDR_CTRL, 8'h31);
    reg_wr(asc_pkg::ADDR_MODE, 8'h00);
    idle();
    repeat (400) @(posedge sys_clk);
    chk("clock source line", 8'h03, 8'(u_peer.rx_q.size()));
    reg_wr(asc_pkg::ADDR_CTRL, 8'h30);
    idle();
    wait_for(0, 4);
    chk("async char", 8'h99, u_peer.rx_q[3][7:0]);
    $display("test stop modes done");
    reg_wr(asc_pkg::ADDR_BRR, 8'h40);
    reg_wr(asc_pkg::ADDR_TDATA, 8'hc3);
    idle();
    u_peer.bit_cyc = 32 * 65;
    wait_for(0, 5);
    chk("slow rate char", 8'hc3, u_peer.rx_q[4][7:0]);
    $display("test bit rate done");
    reg_wr(asc_pkg::ADDR_TDATA, 8'h0f);
    idle();
    repeat (100) @(posedge sys_clk);
    do_reset();
    $display("test mid reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
